// ===== design/irf_top.sv
// Interrupt request flag block: two flag registers, their enables and the request outputs.
// Assumes event inputs are one-cycle pulses and pins are synchronous to the clock.
//
// Overview of operation
// - The direct-transition flag at bit 7 of the primary flags sets when a sleep makes a direct transition while direct_transition_on is 1.
// - Every request flag clears when software writes 0 to it, and all flags reset to 0.
// - The clock overflow flag at bit 6 of the primary flags sets whenever the real-time-clock counter overflows.
// - Each external request flag at bits 3 to 0 sets when its pin is armed for interrupts and its selected edge is seen.
// - Bits 5 and 4 of the primary flags always read 1.
// - The timer overflow flag at bit 5 of the secondary flags sets whenever its timer overflows.
// - Bits 7 and 6 of the secondary flags read 0 and bits 4 to 0 read 1.
// - A request reaches the CPU only while its flag and the enable bit at the same position are both 1.
`timescale 1ns/1ps
`default_nettype none
`include "irf_params.svh"
module irf_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire irf_pkg::irf_addr_t regAddr,
  input wire irf_pkg::irf_byte_t regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output irf_pkg::irf_byte_t regRdData,
  input wire logic sleepDirect,
  input wire logic directTransitionOn,
  input wire logic rtcOverflow,
  input wire logic timerOverflow,
  input wire logic [`IRF_EXT_COUNT-1:0] extRequestPin,
  input wire logic [`IRF_EXT_COUNT-1:0] extPinIrqMode,
  input wire logic [`IRF_EXT_COUNT-1:0] extEdgeRise,
  output logic reqDirectTransition,
  output logic reqClockOverflow,
  output logic [`IRF_EXT_COUNT-1:0] reqExt,
  output logic reqTimerOverflow,
  output logic wakeupEnable,
  output logic irq
);
  logic rstMeta_r;
  logic rstSync_r;
  logic resetSyncN;
  irf_pkg::irf_sel_t sel;
  logic wrFlagsPri;
  logic wrFlagsSec;
  logic wrEnPri;
  logic wrEnSec;
  logic wrClrPri;
  logic wrClrSec;
  logic setDirect;
  logic clrDirect;
  logic clrClock;
  logic clrTimer;
  logic [`IRF_EXT_COUNT-1:0] extEdgeSeen;
  logic [`IRF_EXT_COUNT-1:0] clrExt;
  logic flagDirect;
  logic flagClock;
  logic flagTimer;
  logic [`IRF_EXT_COUNT-1:0] flagExt;
  logic enDirect_r;
  logic enClock_r;
  logic enWake_r;
  logic enTimer_r;
  logic [`IRF_EXT_COUNT-1:0] enExt_r;
  irf_pkg::irf_byte_t flagsPri;
  irf_pkg::irf_byte_t flagsSec;
  irf_pkg::irf_byte_t enPri;
  irf_pkg::irf_byte_t enSec;
  irf_pkg::irf_byte_t regRdData_nxt;

  // The reset is applied at once but released through two flops to avoid a ragged release.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  assign resetSyncN = rstSync_r;

  always_comb begin
    case (regAddr)
      `IRF_OFS_FLAGS_PRI: sel = irf_pkg::IRF_SEL_FLAGS_PRI;
      `IRF_OFS_FLAGS_SEC: sel = irf_pkg::IRF_SEL_FLAGS_SEC;
      `IRF_OFS_EN_PRI: sel = irf_pkg::IRF_SEL_EN_PRI;
      `IRF_OFS_EN_SEC: sel = irf_pkg::IRF_SEL_EN_SEC;
      `IRF_OFS_CLR_PRI: sel = irf_pkg::IRF_SEL_CLR_PRI;
      `IRF_OFS_CLR_SEC: sel = irf_pkg::IRF_SEL_CLR_SEC;
      default: sel = irf_pkg::IRF_SEL_NONE;
    endcase
  end

  assign wrFlagsPri = regWrite && (sel == irf_pkg::IRF_SEL_FLAGS_PRI);
  assign wrFlagsSec = regWrite && (sel == irf_pkg::IRF_SEL_FLAGS_SEC);
  assign wrEnPri = regWrite && (sel == irf_pkg::IRF_SEL_EN_PRI);
  assign wrEnSec = regWrite && (sel == irf_pkg::IRF_SEL_EN_SEC);
  assign wrClrPri = regWrite && (sel == irf_pkg::IRF_SEL_CLR_PRI);
  assign wrClrSec = regWrite && (sel == irf_pkg::IRF_SEL_CLR_SEC);

  // Only a direct transition with the feature switched on counts as an event.
  assign setDirect = sleepDirect && directTransitionOn;

  // A 0 written to a flag clears it, a 1 leaves it alone; the clear register clears on 1.
  assign clrDirect = (wrFlagsPri && !regWrData[`IRF_BIT_DIRECT]) || (wrClrPri && regWrData[`IRF_BIT_DIRECT]);
  assign clrClock = (wrFlagsPri && !regWrData[`IRF_BIT_CLOCK]) || (wrClrPri && regWrData[`IRF_BIT_CLOCK]);
  assign clrTimer = (wrFlagsSec && !regWrData[`IRF_BIT_TIMER]) || (wrClrSec && regWrData[`IRF_BIT_TIMER]);
  assign clrExt = ({`IRF_EXT_COUNT{wrFlagsPri}} & ~regWrData[`IRF_EXT_COUNT-1:`IRF_EXT_LSB])
    | ({`IRF_EXT_COUNT{wrClrPri}} & regWrData[`IRF_EXT_COUNT-1:`IRF_EXT_LSB]);

  // Pins not armed for interrupts never raise a flag.
  irf_edge_detect #(
    .WIDTH(`IRF_EXT_COUNT)
  ) u_edge (
    .clock(clock),
    .resetSyncN(resetSyncN),
    .pinLevel(extRequestPin),
    .riseSelect(extEdgeRise),
    .armed(extPinIrqMode),
    .edgeSeen(extEdgeSeen)
  );

  // Each cell lets its set win over a colliding clear, so no request is lost.
  irf_flag_bit u_flag_direct (
    .clock(clock),
    .resetSyncN(resetSyncN),
    .setEvent(setDirect),
    .clearEvent(clrDirect),
    .flag(flagDirect)
  );

  // The clock overflow pulse sets its flag directly.
  irf_flag_bit u_flag_clock (
    .clock(clock),
    .resetSyncN(resetSyncN),
    .setEvent(rtcOverflow),
    .clearEvent(clrClock),
    .flag(flagClock)
  );

  // The timer overflow pulse sets its flag directly.
  irf_flag_bit u_flag_timer (
    .clock(clock),
    .resetSyncN(resetSyncN),
    .setEvent(timerOverflow),
    .clearEvent(clrTimer),
    .flag(flagTimer)
  );

  for (genvar i = 0; i < `IRF_EXT_COUNT; i++) begin : g_ext
    irf_flag_bit u_flag_ext (
      .clock(clock),
      .resetSyncN(resetSyncN),
      .setEvent(extEdgeSeen[i]),
      .clearEvent(clrExt[i]),
      .flag(flagExt[i])
    );
  end

  always_ff @(posedge clock or negedge resetSyncN) begin
    if (!resetSyncN) begin
      enDirect_r <= `IRF_ENABLE_RESET;
      enClock_r <= `IRF_ENABLE_RESET;
      enWake_r <= `IRF_ENABLE_RESET;
      enExt_r <= '0;
    end else if (wrEnPri) begin
      enDirect_r <= regWrData[`IRF_BIT_DIRECT];
      enClock_r <= regWrData[`IRF_BIT_CLOCK];
      enWake_r <= regWrData[`IRF_BIT_WAKE_EN];
      enExt_r <= regWrData[`IRF_EXT_COUNT-1:`IRF_EXT_LSB];
    end
  end

  always_ff @(posedge clock or negedge resetSyncN) begin
    if (!resetSyncN) begin
      enTimer_r <= `IRF_ENABLE_RESET;
    end else if (wrEnSec) begin
      enTimer_r <= regWrData[`IRF_BIT_TIMER];
    end
  end

  // Reserved bits are forced on the read path and never stored.
  always_comb begin
    flagsPri = `IRF_PRI_RSVD_ONES;
    flagsPri[`IRF_BIT_DIRECT] = flagDirect;
    flagsPri[`IRF_BIT_CLOCK] = flagClock;
    flagsPri[`IRF_EXT_COUNT-1:`IRF_EXT_LSB] = flagExt;
    flagsSec = `IRF_SEC_RSVD_ONES;
    flagsSec[`IRF_BIT_TIMER] = flagTimer;
    enPri = `IRF_ENP_RSVD_ONES;
    enPri[`IRF_BIT_DIRECT] = enDirect_r;
    enPri[`IRF_BIT_CLOCK] = enClock_r;
    enPri[`IRF_BIT_WAKE_EN] = enWake_r;
    enPri[`IRF_EXT_COUNT-1:`IRF_EXT_LSB] = enExt_r;
    enSec = `IRF_SEC_RSVD_ONES;
    enSec[`IRF_BIT_TIMER] = enTimer_r;
  end

  // The clear registers are write-only and read as zero like an unmapped address.
  always_comb begin
    case (sel)
      irf_pkg::IRF_SEL_FLAGS_PRI: regRdData_nxt = flagsPri;
      irf_pkg::IRF_SEL_FLAGS_SEC: regRdData_nxt = flagsSec;
      irf_pkg::IRF_SEL_EN_PRI: regRdData_nxt = enPri;
      irf_pkg::IRF_SEL_EN_SEC: regRdData_nxt = enSec;
      default: regRdData_nxt = `IRF_READ_IDLE;
    endcase
  end

  // Read data stand for the one cycle after the strobe only.
  always_ff @(posedge clock or negedge resetSyncN) begin
    if (!resetSyncN) begin
      regRdData <= `IRF_READ_IDLE;
    end else if (regRead) begin
      regRdData <= regRdData_nxt;
    end else begin
      regRdData <= `IRF_READ_IDLE;
    end
  end

  // Requests are gated by enables so a pending flag waits quietly until enabled.
  assign reqDirectTransition = flagDirect && enDirect_r;
  assign reqClockOverflow = flagClock && enClock_r;
  assign reqExt = flagExt & enExt_r;
  assign reqTimerOverflow = flagTimer && enTimer_r;
  assign irq = reqDirectTransition || reqClockOverflow || (|reqExt) || reqTimerOverflow;
  assign wakeupEnable = enWake_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetSyncN);

  chk_direct_set: assert property (sleepDirect && directTransitionOn |=> flagDirect)
    else $error("direct transition did not set its flag");
  chk_direct_cause: assert property ($rose(flagDirect) |-> $past(sleepDirect && directTransitionOn))
    else $error("direct flag rose without an enabled transition");
  chk_clear_by_zero: assert property (
    wrFlagsPri && !regWrData[`IRF_BIT_CLOCK] && !rtcOverflow |=> !flagClock)
    else $error("writing zero did not clear the clock flag");
  chk_clock_set: assert property (rtcOverflow |=> flagClock [*2] or (flagClock ##1 $past(clrClock)))
    else $error("clock overflow flag not held after its event");
  chk_ext_set: assert property (extEdgeSeen[0] |=> flagExt[0])
    else $error("edge on pin zero did not set its flag");
  chk_ext_armed: assert property ($rose(flagExt[1]) |-> $past(extPinIrqMode[1]))
    else $error("unarmed pin raised a flag");
  chk_pri_reserved: assert property (regRead && sel == irf_pkg::IRF_SEL_FLAGS_PRI |=> regRdData[5:4] == 2'h3)
    else $error("primary reserved bits not read as one");
  chk_timer_set: assert property (timerOverflow |=> flagTimer)
    else $error("timer overflow did not set its flag");
  chk_sec_reserved: assert property (
    regRead && sel == irf_pkg::IRF_SEL_FLAGS_SEC |=> regRdData[7:6] == 2'h0 && regRdData[4:0] == 5'h1f)
    else $error("secondary reserved bits read wrong");
  chk_request_gate: assert property (enTimer_r && timerOverflow && !wrEnSec |=> reqTimerOverflow && irq)
    else $error("enabled timer flag did not raise a request");
  chk_masked_quiet: assert property (!enClock_r && !enDirect_r && enExt_r == 4'h0 && !enTimer_r |-> !irq)
    else $error("interrupt raised with every enable clear");
  chk_write_one: assert property (wrFlagsPri && regWrData[`IRF_BIT_CLOCK] && flagClock |=> flagClock)
    else $error("writing one changed the clock flag");
  chk_set_wins: assert property (timerOverflow && clrTimer |=> flagTimer)
    else $error("clear beat a colliding set");
  chk_read_idle: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data stood outside its cycle");

  // Each flag may rise only after its own event; the direct, clock, timer and external flag 3 checks make a stray set path show up at once.
  chk_direct_refused: assert property (sleepDirect && !directTransitionOn && !flagDirect |=> !flagDirect)
    else $error("direct transition flag set while the feature was off");
  chk_clock_cause: assert property ($rose(flagClock) |-> $past(rtcOverflow))
    else $error("clock overflow flag rose without an overflow");
  chk_timer_cause: assert property ($rose(flagTimer) |-> $past(timerOverflow))
    else $error("timer overflow flag rose without an overflow");
  chk_ext_cause: assert property ($rose(flagExt[3]) |-> $past(extEdgeSeen[3]))
    else $error("external flag three rose without an edge");
  chk_timer_clear: assert property (
    wrFlagsSec && !regWrData[`IRF_BIT_TIMER] && !timerOverflow |=> !flagTimer)
    else $error("writing zero did not clear the timer flag");
  chk_timer_clear_reg: assert property (
    wrClrSec && regWrData[`IRF_BIT_TIMER] && !timerOverflow |=> !flagTimer)
    else $error("clear register did not clear the timer flag");
  chk_clear_reg: assert property (
    wrClrPri && regWrData[`IRF_BIT_DIRECT] && !setDirect |=> !flagDirect)
    else $error("clear register did not clear the direct flag");
  chk_ext_clear: assert property (
    wrFlagsPri && regWrData[`IRF_EXT_COUNT-1:`IRF_EXT_LSB] == '0 && extEdgeSeen == '0 |=> flagExt == '0)
    else $error("writing zero did not clear the external flags");
  chk_read_flags: assert property (
    regRead && sel == irf_pkg::IRF_SEL_FLAGS_PRI |=> regRdData[`IRF_EXT_COUNT-1:`IRF_EXT_LSB] == $past(flagExt))
    else $error("external flags read back wrong");
  chk_en_reserved: assert property (
    regRead && sel == irf_pkg::IRF_SEL_EN_SEC |=> regRdData[7:6] == 2'h0 && regRdData[4:0] == 5'h1f)
    else $error("secondary enable reserved bits read wrong");
  chk_timer_one: assert property (
    wrFlagsSec && regWrData[`IRF_BIT_TIMER] && flagTimer |=> flagTimer)
    else $error("writing one changed the timer flag");
  chk_gate_enable: assert property (
    irq |-> ((flagsPri & enPri & 8'hcf) != 8'h00) || (flagTimer && enTimer_r))
    else $error("interrupt raised without an enabled pending flag");

  cov_direct_irq: cover property (setDirect && enDirect_r ##1 irq);
  cov_set_clear_clash: cover property (rtcOverflow && clrClock);
  cov_ext_fall: cover property (extEdgeSeen[2] && !extEdgeRise[2]);
  cov_clear_reg: cover property (flagTimer && wrClrSec && regWrData[`IRF_BIT_TIMER] ##1 !flagTimer);
  cov_timer_irq: cover property (timerOverflow && enTimer_r ##1 irq);
endmodule
`default_nettype wire

// ===== shared/irf_params.svh
// Constants of the interrupt request flag block: offsets, bit positions, reset values.
// Assumes inclusion by bare name from any file that needs them.
`ifndef IRF_PARAMS_SVH
`define IRF_PARAMS_SVH

`define IRF_ADDR_W 3
`define IRF_EXT_COUNT 4

`define IRF_OFS_FLAGS_PRI 3'h0
`define IRF_OFS_FLAGS_SEC 3'h1
`define IRF_OFS_EN_PRI 3'h2
`define IRF_OFS_EN_SEC 3'h3
`define IRF_OFS_CLR_PRI 3'h4
`define IRF_OFS_CLR_SEC 3'h5

`define IRF_BIT_DIRECT 7
`define IRF_BIT_CLOCK 6
`define IRF_BIT_WAKE_EN 5
`define IRF_BIT_TIMER 5
`define IRF_EXT_LSB 0

`define IRF_FLAG_RESET 1'b0
`define IRF_ENABLE_RESET 1'b0
`define IRF_PRI_RSVD_ONES 8'h30
`define IRF_ENP_RSVD_ONES 8'h10
`define IRF_SEC_RSVD_ONES 8'h1f
`define IRF_READ_IDLE 8'h00

`endif

// ===== shared/irf_pkg.sv
// Types shared by the interrupt request flag block.
// Assumes the constants header is compiled alongside.
package irf_pkg;
  typedef logic [7:0] irf_byte_t;
  typedef logic [2:0] irf_addr_t;
  typedef enum logic [2:0] {
    IRF_SEL_NONE,
    IRF_SEL_FLAGS_PRI,
    IRF_SEL_FLAGS_SEC,
    IRF_SEL_EN_PRI,
    IRF_SEL_EN_SEC,
    IRF_SEL_CLR_PRI,
    IRF_SEL_CLR_SEC
  } irf_sel_t;
endpackage

// ===== design/irf_flag_bit.sv
// One sticky request flag with a set input and a clear input.
// Assumes set and clear are single-cycle requests synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
`include "irf_params.svh"
module irf_flag_bit (
  input wire logic clock,
  input wire logic resetSyncN,
  input wire logic setEvent,
  input wire logic clearEvent,
  output logic flag
);
  // A set in the cycle of a clear must survive, so set is tested first.
  always_ff @(posedge clock or negedge resetSyncN) begin
    if (!resetSyncN) begin
      flag <= `IRF_FLAG_RESET;
    end else if (setEvent) begin
      flag <= 1'b1;
    end else if (clearEvent) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== design/irf_edge_detect.sv
// Edge detector for the external request pins with per-pin edge select and arming.
// Assumes pin levels are already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module irf_edge_detect #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic resetSyncN,
  input wire logic [WIDTH-1:0] pinLevel,
  input wire logic [WIDTH-1:0] riseSelect,
  input wire logic [WIDTH-1:0] armed,
  output logic [WIDTH-1:0] edgeSeen
);
  logic [WIDTH-1:0] prev_r;
  logic primed_r;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  // The first sample after reset only primes the history, so no false edge is seen.
  always_ff @(posedge clock or negedge resetSyncN) begin
    if (!resetSyncN) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r <= pinLevel;
      primed_r <= 1'b1;
    end
  end

  assign rise = pinLevel & ~prev_r;
  assign fall = ~pinLevel & prev_r;
  assign edgeSeen = primed_r ? (armed & ((riseSelect & rise) | (~riseSelect & fall))) : '0;
endmodule
`default_nettype wire

// ===== test/irf_event_source.sv
// Event source model: sleep, clock and timer overflow pulses and the four request pins.
// Assumes one go pulse per request, issued only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module irf_event_source (
  input wire logic clock,
  input wire logic go,
  input wire logic [2:0] pulseSel,
  input wire logic [3:0] pinFlip,
  input wire logic [3:0] gap,
  output logic sleepDirect,
  output logic rtcOverflow,
  output logic timerOverflow,
  output logic [3:0] extRequestPin,
  output logic busy
);
  logic [3:0] count;
  logic [2:0] selHeld;
  logic [3:0] flipHeld;
  initial begin
    {sleepDirect, rtcOverflow, timerOverflow, busy} = 4'h0;
    extRequestPin = 4'h0;
  end
  // A nonzero gap makes the source slow, so events can land on any cycle of the bus traffic.
  always @(posedge clock) begin
    {sleepDirect, rtcOverflow, timerOverflow} <= 3'h0;
    if (go && !busy) begin
      busy <= 1'b1;
      count <= gap;
      selHeld <= pulseSel;
      flipHeld <= pinFlip;
    end else if (busy && count != 4'h0) begin
      count <= count - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      {sleepDirect, rtcOverflow, timerOverflow} <= selHeld;
      extRequestPin <= extRequestPin ^ flipHeld;
    end
  end
endmodule
`default_nettype wire

// ===== test/irf_top_tb.sv
// Self-checking bench for the interrupt request flag block against a cycle model.
// Assumes the event source model and the design files are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "irf_params.svh"
module irf_top_tb;
  logic clock, reset_n, regWrite, regRead, go, directOn, sleepDirect, rtcOverflow, timerOverflow, busy;
  logic mS, mT, wake, irq, reqD, reqC, reqT;
  irf_pkg::irf_addr_t regAddr;
  irf_pkg::irf_byte_t regWrData, regRdData, lfsr, expRd, mP, mE;
  logic [3:0] pins, prevPin, mode, rise, reqX, flip, gap;
  logic [2:0] sel;
  int miscompares, comparisons;
  wire irf_pkg::irf_byte_t clrP = !regWrite ? 8'h00 : regAddr == `IRF_OFS_FLAGS_PRI ? ~regWrData & 8'hcf :
    regAddr == `IRF_OFS_CLR_PRI ? regWrData & 8'hcf : 8'h00;
  wire logic clrS = regWrite && (regAddr == `IRF_OFS_FLAGS_SEC ? !regWrData[5] :
    regAddr == `IRF_OFS_CLR_SEC && regWrData[5]);
  irf_top irf_top_inst (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .sleepDirect(sleepDirect),
    .directTransitionOn(directOn), .rtcOverflow(rtcOverflow), .timerOverflow(timerOverflow),
    .extRequestPin(pins), .extPinIrqMode(mode), .extEdgeRise(rise), .reqDirectTransition(reqD),
    .reqClockOverflow(reqC), .reqExt(reqX), .reqTimerOverflow(reqT), .wakeupEnable(wake), .irq(irq));
  irf_event_source irf_event_source_inst (.clock(clock), .go(go), .pulseSel(sel), .pinFlip(flip),
    .gap(gap), .sleepDirect(sleepDirect), .rtcOverflow(rtcOverflow), .timerOverflow(timerOverflow),
    .extRequestPin(pins), .busy(busy));
  function automatic irf_pkg::irf_byte_t nextLfsr(input irf_pkg::irf_byte_t v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic irf_pkg::irf_byte_t expRead(input irf_pkg::irf_addr_t a);
    case (a)
      3'h0: return {mP[7:6], 2'h3, mP[3:0]};
      3'h1: return {2'h0, mS, 5'h1f};
      3'h2: return {mE[7:5], 1'h1, mE[3:0]};
      3'h3: return {2'h0, mT, 5'h1f};
      default: return 8'h00;
    endcase
  endfunction
  // The model sees the same pre-edge inputs as the design, so both update on one edge.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {mP, mE, expRd} <= 24'h0;
      {mS, mT} <= 2'h0;
      prevPin <= pins;
    end else begin
      prevPin <= pins;
      expRd <= regRead ? expRead(regAddr) : 8'h00;
      mP <= (mP & ~clrP) | {sleepDirect & directOn, rtcOverflow, 2'h0, mode & (pins ^ prevPin) & ~(pins ^ rise)};
      mS <= (mS & !clrS) | timerOverflow;
      if (regWrite && regAddr == `IRF_OFS_EN_PRI) mE <= regWrData & 8'hef;
      if (regWrite && regAddr == `IRF_OFS_EN_SEC) mT <= regWrData[5];
    end
  end
  always @(negedge clock) begin
    if (reset_n) begin
      check({1'h0, regRdData}, {1'h0, expRd});
      check({reqD, reqC, reqX, reqT, wake, irq},
        {mP[7:6] & mE[7:6], mP[3:0] & mE[3:0], mS & mT, mE[5], |(mP & mE & 8'hcf) | (mS & mT)});
    end
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input irf_pkg::irf_addr_t a, input irf_pkg::irf_byte_t d);
    @(posedge clock);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWrData <= d;
  endtask
  task automatic idle();
    @(posedge clock);
    regWrite <= 1'b0;
    regRead <= 1'b0;
  endtask
  task automatic fire(input logic [2:0] s, input logic [3:0] f, input logic [3:0] g, input bit waitDone);
    int n;
    n = 0;
    @(posedge clock);
    go <= 1'b1;
    sel <= s;
    flip <= f;
    gap <= g;
    @(posedge clock);
    go <= 1'b0;
    while (waitDone && n < 40) begin
      @(negedge clock);
      if (!busy) break;
      n++;
    end
    if (n == 40) begin
      miscompares++;
      give_verdict();
    end
    if (waitDone) repeat (2) @(posedge clock);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {reset_n, regWrite, regRead, go, directOn} = 5'h0;
    {regAddr, regWrData, mode, rise, flip, gap, sel} = 30'h0;
    lfsr = 8'h0a;
    miscompares = 0;
    comparisons = 0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int a = 0; a < 8; a++) bus(1'b0, a[2:0], 8'h00);
    bus(1'b1, 3'h6, 8'hff);
    bus(1'b1, 3'h7, 8'hff);
    bus(1'b0, 3'h6, 8'h00);
    bus(1'b0, 3'h7, 8'h00);
    for (int a = 0; a < 4; a++) bus(1'b0, a[2:0], 8'h00);
    idle();
    $display("test reset and map done");
    for (int i = 0; i < 24; i++) begin
      lfsr = nextLfsr(lfsr);
      mode <= lfsr[3:0];
      rise <= lfsr[7:4];
      directOn <= lfsr[1];
      bus(1'b1, `IRF_OFS_EN_PRI, lfsr);
      bus(1'b1, `IRF_OFS_EN_SEC, ~lfsr);
      bus(1'b0, `IRF_OFS_EN_PRI, 8'h00);
      bus(1'b0, `IRF_OFS_EN_SEC, 8'h00);
      idle();
      fire(lfsr[2:0], lfsr[7:4] ^ lfsr[3:0], lfsr[3:0], 1);
      bus(1'b0, `IRF_OFS_FLAGS_PRI, 8'h00);
      bus(1'b0, `IRF_OFS_FLAGS_SEC, 8'h00);
      bus(1'b1, lfsr[0] ? `IRF_OFS_FLAGS_PRI : `IRF_OFS_CLR_PRI, nextLfsr(lfsr));
      bus(1'b1, lfsr[1] ? `IRF_OFS_FLAGS_SEC : `IRF_OFS_CLR_SEC, nextLfsr(lfsr));
      idle();
    end
    $display("test random events done");
    // Clears run unmasked on every cycle, so the event is sure to collide with one of them.
    directOn <= 1'b1;
    bus(1'b1, `IRF_OFS_EN_PRI, 8'hff);
    bus(1'b1, `IRF_OFS_EN_SEC, 8'hff);
    idle();
    for (int j = 0; j < 2; j++) begin
      fire(3'h7, 4'h0, 4'h2, 0);
      repeat (10) bus(1'b1, j ? `IRF_OFS_CLR_SEC : `IRF_OFS_FLAGS_PRI, j ? 8'hff : 8'h00);
      idle();
      repeat (3) @(posedge clock);
    end
    $display("test collision done");
    give_verdict();
  end
endmodule
`default_nettype wire
